// ---- iop_defines.vh ----
// register offsets, reset values and widths for the io port block
`ifndef IOP_DEFINES_VH
`define IOP_DEFINES_VH

// ---------------------------------------------------------------
// register indices (port base + register)
// ---------------------------------------------------------------
`define IOP_ADDR_W        4
`define IOP_REG_FSEL      2'h0
`define IOP_REG_DVAL      2'h1
`define IOP_REG_PAD       2'h2
`define IOP_REG_DEN       2'h3
`define IOP_PORT_A        2'h0
`define IOP_PORT_B        2'h1
`define IOP_PORT_C        2'h2

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define IOP_RST_FSEL      8'h00
`define IOP_RST_DEN       8'h00
`define IOP_RST_DVAL      8'h00

// ---------------------------------------------------------------
// alternate direction per port: 1 = output type
// ---------------------------------------------------------------
`define IOP_ALT_OUT_A     8'hFF
`define IOP_ALT_OUT_B     8'h88
`define IOP_ALT_OUT_C     8'hC2
`define IOP_PORT_A_A_SMALL   8'h03

`endif

// ---- iop_sync.v ----
// two-flop synchroniser for pad levels
`timescale 1ns/10ps
module iop_sync #(
    parameter WIDTH = 8
) (
    input  wire             clk_sys,
    input  wire             rstn,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            meta_q   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule // iop_sync

// ---- iop_port_mux.v ----
// three 8-bit io ports with alternate function multiplexing
// Operation
// - three memory-mapped 8-bit ports give twenty-four pins
// - reduced package keeps ports b, c and only two port a bits
// - each pin has a processor-written drive value latch
// - drive enable 0 makes input, 1 drives the latched value
// - pad level bit reads the real pin level, except port a bits 7:2 read 0 in the reduced package
// - function select 0 gives io, 1 gives alternate function
// - port a alternates are timer, memory strobe and uart outputs
// - port b alternates are timer2, uart1 and interrupt signals
// - port c alternates are uart0, interrupts, timer clocks, strobes
// - output alternate with select 0 is fully disconnected
// - output alternate with select 1 drives pin, latch disconnected
// - input alternate always fed from pad whatever the mode
// - input alternate with select 1 disconnects latch and buffer
// - at reset all selects and enables are zero
`timescale 1ns/10ps
`include "iop_defines.vh"
module iop_port_mux #(
    parameter SMALL_PKG = 0
) (
    input  wire        clk_sys,
    input  wire        rstn,
    // processor register port
    input  wire [3:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    // pins
    input  wire [7:0]  port_a_in,
    output reg  [7:0]  port_a_out,
    output reg  [7:0]  port_a_oe,
    input  wire [7:0]  port_b_in,
    output reg  [7:0]  port_b_out,
    output reg  [7:0]  port_b_oe,
    input  wire [7:0]  port_c_in,
    output reg  [7:0]  port_c_out,
    output reg  [7:0]  port_c_oe,
    // alternate outputs
    input  wire        timer0_overflow_pulse,
    input  wire        timer1_overflow_pulse,
    input  wire        ext_mem_oe_n,
    input  wire        ext_mem_cs_n,
    input  wire        fast_store_strobe,
    input  wire        fast_fetch_strobe,
    input  wire        uart0_sync_data_out,
    input  wire        uart1_sync_data_out,
    input  wire        uart1_tx_line,
    input  wire        timer2_overflow_pulse,
    input  wire        uart0_tx_line,
    input  wire        write_strobe_n,
    input  wire        read_strobe_n,
    // alternate inputs
    output reg         timer2_count_in,
    output reg         timer2_capture_reload_in,
    output reg         uart1_rx_line,
    output reg         ext_irq4_in,
    output reg         ext_irq5_in,
    output reg         ext_irq6_in,
    output reg         uart0_rx_line,
    output reg         ext_irq0_low_in,
    output reg         ext_irq1_low_in,
    output reg         timer0_count_in,
    output reg         timer1_count_in
);
    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    reg  [7:0]  fsel_q [0:2];
    reg  [7:0]  dval_q [0:2];
    reg  [7:0]  den_q  [0:2];
    wire [7:0]  pad_a;
    wire [7:0]  pad_b;
    wire [7:0]  pad_c;
    wire [7:0]  alt_a;
    wire [7:0]  alt_b;
    wire [7:0]  alt_c;
    wire [7:0]  pin_mask_a;
    wire [1:0]  sel_port;
    wire [1:0]  sel_reg;
    integer     i;

    assign sel_port = reg_addr[3:2];
    assign sel_reg  = reg_addr[1:0];
    assign pin_mask_a = (SMALL_PKG != 0) ? `IOP_PORT_A_A_SMALL : 8'hFF;

    // ---------------------------------------------------------------
    // pad synchronisers
    // ---------------------------------------------------------------
    iop_sync #(.WIDTH(24)) u_sync (
        .clk_sys  (clk_sys),
        .rstn     (rstn),
        .async_in ({port_c_in, port_b_in, port_a_in}),
        .sync_out ({pad_c, pad_b, pad_a})
    );

    // ---------------------------------------------------------------
    // alternate output vectors
    // ---------------------------------------------------------------
    assign alt_a = {uart1_sync_data_out, uart0_sync_data_out,
                    fast_fetch_strobe, fast_store_strobe,
                    ext_mem_cs_n, ext_mem_oe_n,
                    timer1_overflow_pulse, timer0_overflow_pulse};
    assign alt_b = {timer2_overflow_pulse, 3'h0, uart1_tx_line,
                    3'h0};
    assign alt_c = {read_strobe_n, write_strobe_n, 4'h0,
                    uart0_tx_line, 1'b0};

    // pin drive: select 0 uses latch and enable, 1 uses alternate
    function [15:0] pin_drive;
        input [7:0] fsel;
        input [7:0] dval;
        input [7:0] den;
        input [7:0] alt;
        input [7:0] alt_is_out;
        input [7:0] mask;
        reg   [7:0] o;
        reg   [7:0] e;
        begin
            o = (dval & ~fsel) | (alt & fsel & alt_is_out);
            e = ((den & ~fsel) | (fsel & alt_is_out)) & mask;
            pin_drive = {e, o};
        end
    endfunction

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < 3; i = i + 1) begin
                fsel_q[i] <= `IOP_RST_FSEL;
                den_q[i]  <= `IOP_RST_DEN;
                dval_q[i] <= `IOP_RST_DVAL;
            end
        end else if (reg_wr && sel_port != 2'h3) begin
            case (sel_reg)
                `IOP_REG_FSEL: fsel_q[sel_port] <= reg_wdata;
                `IOP_REG_DVAL: dval_q[sel_port] <= reg_wdata;
                `IOP_REG_DEN:  den_q[sel_port]  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // read data and pin/alternate outputs, all registered
    // ---------------------------------------------------------------
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata  <= 8'h00;
            port_a_out <= 8'h00;
            port_a_oe  <= 8'h00;
            port_b_out <= 8'h00;
            port_b_oe  <= 8'h00;
            port_c_out <= 8'h00;
            port_c_oe  <= 8'h00;
            timer2_count_in          <= 1'b0;
            timer2_capture_reload_in <= 1'b0;
            uart1_rx_line            <= 1'b1;
            ext_irq4_in              <= 1'b0;
            ext_irq5_in              <= 1'b0;
            ext_irq6_in              <= 1'b0;
            uart0_rx_line            <= 1'b1;
            ext_irq0_low_in          <= 1'b1;
            ext_irq1_low_in          <= 1'b1;
            timer0_count_in          <= 1'b0;
            timer1_count_in          <= 1'b0;
        end else begin
            {port_a_oe, port_a_out} <= pin_drive(fsel_q[0], dval_q[0],
                den_q[0], alt_a, `IOP_ALT_OUT_A, pin_mask_a);
            {port_b_oe, port_b_out} <= pin_drive(fsel_q[1], dval_q[1],
                den_q[1], alt_b, `IOP_ALT_OUT_B, 8'hFF);
            {port_c_oe, port_c_out} <= pin_drive(fsel_q[2], dval_q[2],
                den_q[2], alt_c, `IOP_ALT_OUT_C, 8'hFF);
            // input alternates always listen to the pad
            timer2_count_in          <= pad_b[0];
            timer2_capture_reload_in <= pad_b[1];
            uart1_rx_line            <= pad_b[2];
            ext_irq4_in              <= pad_b[4];
            ext_irq5_in              <= pad_b[5];
            ext_irq6_in              <= pad_b[6];
            uart0_rx_line            <= pad_c[0];
            ext_irq0_low_in          <= pad_c[2];
            ext_irq1_low_in          <= pad_c[3];
            timer0_count_in          <= pad_c[4];
            timer1_count_in          <= pad_c[5];
            case (sel_reg)
                `IOP_REG_FSEL: reg_rdata <= (sel_port == 2'h3) ? 8'h00
                                            : fsel_q[sel_port];
                `IOP_REG_DVAL: reg_rdata <= (sel_port == 2'h3) ? 8'h00
                                            : dval_q[sel_port];
                `IOP_REG_PAD: begin
                    case (sel_port)
                        `IOP_PORT_A: reg_rdata <= pad_a & pin_mask_a;
                        `IOP_PORT_B: reg_rdata <= pad_b;
                        `IOP_PORT_C: reg_rdata <= pad_c;
                        default:     reg_rdata <= 8'h00;
                    endcase
                end
                default: reg_rdata <= (sel_port == 2'h3) ? 8'h00
                                      : den_q[sel_port];
            endcase
        end
    end
endmodule // iop_port_mux

// ---- iop_board.sv ----
// board side model of one 8-bit port
`timescale 1ns/10ps
module iop_board (
    input  logic [7:0] out,
    input  logic [7:0] oe,
    input  logic [7:0] ext,
    output logic [7:0] pad
);
    // undriven bits settle to the board level
    assign pad = (out & oe) | (ext & ~oe);
endmodule // iop_board

// ---- iop_checker.sv ----
// port assertions for the io port block
`timescale 1ns/10ps
module iop_checker (
    input logic       clk_sys,
    input logic       rstn,
    input logic [3:0] reg_addr,
    input logic       reg_wr,
    input logic [7:0] reg_rdata,
    input logic [7:0] port_b_in,
    input logic [7:0] port_c_in,
    input logic [7:0] port_b_oe,
    input logic [7:0] port_c_oe,
    input logic [7:0] port_c_out,
    input logic       timer2_count_in,
    input logic       ext_irq0_low_in
);
    logic [2:0] stab_q;
    wire        q = stab_q == 3'h6;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // pads quiet for six edges
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) stab_q <= 3'h0;
        else if (!$stable({port_c_in, port_b_in})) stab_q <= 3'h0;
        else if (stab_q != 3'h6) stab_q <= stab_q + 3'h1;
    end
    property p_rst; $rose(rstn) |-> port_b_oe == 8'h00 && port_c_oe == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("oe set after reset");
    property p_oe; $changed(port_c_oe[5:2]) |-> $past(reg_wr, 2)
        && $past(reg_addr, 2) inside {4'h8, 4'hB}; endproperty
    a_oe: assert property (p_oe) else $error("oe moved unasked");
    property p_out; $changed(port_c_out[5:2]) |-> $past(reg_wr, 2)
        && $past(reg_addr, 2) inside {4'h8, 4'h9}; endproperty
    a_out: assert property (p_out) else $error("out moved unasked");
    property p_pad; q && $stable({port_c_in, port_b_in})
        && $past(reg_addr) == 4'h6 |-> reg_rdata == port_b_in; endproperty
    a_pad: assert property (p_pad) else $error("pad read wrong");
    property p_unm; $past(reg_addr[3:2]) == 2'h3 |-> reg_rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read");
    property p_t2; q && $stable({port_c_in, port_b_in})
        |-> timer2_count_in == port_b_in[0]; endproperty
    a_t2: assert property (p_t2) else $error("timer2 input off");
    property p_irq; q && $stable({port_c_in, port_b_in})
        |-> ext_irq0_low_in == port_c_in[2]; endproperty
    a_irq: assert property (p_irq) else $error("irq0 input off");
    property p_sync; $changed(port_b_in[0]) |=> $stable(timer2_count_in) [*2]; endproperty
    a_sync: assert property (p_sync) else $error("pad not delayed");
endmodule // iop_checker
bind iop_port_mux iop_checker i_chk (.*);

// ---- tb.sv ----
// self-checking bench for the io port block
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("unexpected %0t: got %h exp %h", $time, a, b); end end
module tb;
    logic        clk_sys = 0, rstn = 0, reg_wr = 0;
    logic [3:0]  reg_addr = 0;
    logic [7:0]  reg_wdata = 0, a_ext = 0, b_ext = 0, c_ext = 0;
    logic [12:0] alt = 0;
    wire  [7:0]  rdata, a_in, b_in, c_in, a_o, b_o, c_o, a_oe, b_oe, c_oe;
    wire  [10:0] ai;
    wire  [7:0]  s_rdata, s_aoe;
    int          n_fail = 0, checks = 0;
    iop_port_mux i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(rdata),
        .port_a_in(a_in), .port_a_out(a_o), .port_a_oe(a_oe),
        .port_b_in(b_in), .port_b_out(b_o), .port_b_oe(b_oe),
        .port_c_in(c_in), .port_c_out(c_o), .port_c_oe(c_oe),
        .timer0_overflow_pulse(alt[0]), .timer1_overflow_pulse(alt[1]),
        .ext_mem_oe_n(alt[2]), .ext_mem_cs_n(alt[3]),
        .fast_store_strobe(alt[4]), .fast_fetch_strobe(alt[5]),
        .uart0_sync_data_out(alt[6]), .uart1_sync_data_out(alt[7]),
        .uart1_tx_line(alt[8]), .timer2_overflow_pulse(alt[9]),
        .uart0_tx_line(alt[10]), .write_strobe_n(alt[11]),
        .read_strobe_n(alt[12]), .timer2_count_in(ai[0]),
        .timer2_capture_reload_in(ai[1]), .uart1_rx_line(ai[2]),
        .ext_irq4_in(ai[3]), .ext_irq5_in(ai[4]), .ext_irq6_in(ai[5]),
        .uart0_rx_line(ai[6]), .ext_irq0_low_in(ai[7]),
        .ext_irq1_low_in(ai[8]), .timer0_count_in(ai[9]),
        .timer1_count_in(ai[10]));
    iop_board i_ba (.out(a_o), .oe(a_oe), .ext(a_ext), .pad(a_in));
    iop_board i_bb (.out(b_o), .oe(b_oe), .ext(b_ext), .pad(b_in));
    iop_board i_bc (.out(c_o), .oe(c_oe), .ext(c_ext), .pad(c_in));
    // reduced package variant shares the bus and the port a pads
    iop_port_mux #(.SMALL_PKG(1)) i_dut_s (.clk_sys(clk_sys), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(s_rdata), .port_a_in(a_in), .port_a_out(),
        .port_a_oe(s_aoe), .port_b_in(b_in), .port_b_out(), .port_b_oe(),
        .port_c_in(c_in), .port_c_out(), .port_c_oe(),
        .timer0_overflow_pulse(alt[0]), .timer1_overflow_pulse(alt[1]),
        .ext_mem_oe_n(alt[2]), .ext_mem_cs_n(alt[3]),
        .fast_store_strobe(alt[4]), .fast_fetch_strobe(alt[5]),
        .uart0_sync_data_out(alt[6]), .uart1_sync_data_out(alt[7]),
        .uart1_tx_line(alt[8]), .timer2_overflow_pulse(alt[9]),
        .uart0_tx_line(alt[10]), .write_strobe_n(alt[11]),
        .read_strobe_n(alt[12]), .timer2_count_in(),
        .timer2_capture_reload_in(), .uart1_rx_line(), .ext_irq4_in(),
        .ext_irq5_in(), .ext_irq6_in(), .uart0_rx_line(),
        .ext_irq0_low_in(), .ext_irq1_low_in(), .timer0_count_in(),
        .timer1_count_in());
    initial forever #50 clk_sys = ~clk_sys;
    // ---------------------------------------------------------------
    // bus tasks and scenarios
    // ---------------------------------------------------------------
    task automatic settle;
        repeat (7) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        settle;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(rdata, e)
    endtask
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
    endtask
    task automatic t_reset;
        for (int p = 0; p < 3; p++) begin
            rd_chk(4'(4 * p), 8'h00);
            rd_chk(4'(4 * p + 3), 8'h00);
        end
        `CHK({a_oe, b_oe, c_oe}, 24'h000000)
    endtask
    task automatic t_gpio;
        b_ext <= 8'h0F;
        wr(4'h5, 8'h5A);
        wr(4'h7, 8'hF0);
        `CHK(b_oe, 8'hF0)
        `CHK(b_o & b_oe, 8'h50)
        rd_chk(4'h6, 8'h5F);
        rd_chk(4'h5, 8'h5A);
        `CHK(ai[5:0], 6'h2F)
    endtask
    task automatic t_alt_out;
        @(posedge clk_sys);
        alt <= 13'h16FF;
        wr(4'h1, 8'h00);
        wr(4'h3, 8'hFF);
        rd_chk(4'h2, 8'h00);
        wr(4'h0, 8'hFF);
        `CHK(a_oe, 8'hFF)
        `CHK(s_aoe, 8'h03)
        rd_chk(4'h2, 8'hFF);
        `CHK(s_rdata, 8'h03)
        @(posedge clk_sys);
        alt[7:0] <= 8'h96;
        settle;
        rd_chk(4'h2, 8'h96);
        wr(4'h4, 8'h88);
        rd_chk(4'h6, 8'hD7);
    endtask
    task automatic t_refuse;
        wr(4'hC, 8'hFF);
        rd_chk(4'hC, 8'h00);
        rd_chk(4'hF, 8'h00);
        wr(4'hF, 8'h00);
        rd_chk(4'h3, 8'hFF);
        rd_chk(4'h7, 8'hF0);
        wr(4'h6, 8'h00);
        rd_chk(4'h6, 8'hD7);
    endtask
    task automatic t_alt_in;
        c_ext <= 8'h3C;
        wr(4'h9, 8'h24);
        wr(4'hB, 8'hFF);
        `CHK(ai[10:6], 5'h12)
        wr(4'h8, 8'hFF);
        rd_chk(4'hA, 8'hBE);
        `CHK(c_oe, 8'hC2)
        `CHK(ai[10:6], 5'h1E)
    endtask
    task automatic test_done;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #5000000;
        n_fail++;
        test_done;
    end
    initial begin
        do_reset;
        t_reset;
        t_gpio;
        t_alt_out;
        t_refuse;
        t_alt_in;
        @(posedge clk_sys);
        do_reset;
        t_reset;
        test_done;
    end
endmodule // tb
